// File: include/txcfg_pkg.sv
// constants for the transmit setup and transmit outcome status block
// assumes a 20 MHz system clock and a plain strobe register port
// Function
// - crc inhibit 0 appends fcs, 1 omits
// - crc inhibit also applies in loopback
// - two-bit field selects loopback mode
// - loopback output high only in mode 10
// - loopback field bits reset to zero
// - hash 62 disables, 63 enables transmitter
// - clearing auto disable re-enables transmitter
// - offset backoff for first three collisions
// - status cleared when host starts transmission
// - status bits low unless event occurs
// - sent ok only without abort or underrun
// - collided bit set, count kept separately
// - abort after sixteen attempts from collisions
// - carrier loss flagged, transmission continues
// - fifo underrun flagged, packet aborted
// - heartbeat fail if none within 6.4 us
// - late collision flagged, still rescheduled
// - loopback select 0 means loopback
package txcfg_pkg;
  localparam logic [3:0] ADDR_STATUS    = 4'h4;
  localparam logic [3:0] ADDR_SETUP     = 4'hd;
  localparam logic [3:0] ADDR_DATACFG   = 4'he;
  localparam logic [3:0] ADDR_COLLCOUNT = 4'h5;
  // setup fields
  localparam int SET_CRC_INH = 0;
  localparam int SET_LB_LOW  = 1;
  localparam int SET_LB_HIGH = 2;
  localparam int SET_AUTO_DIS     = 3;
  localparam int SET_COLL_OFS     = 4;
  localparam int DATACFG_LOOP_SEL = 3;
  // status fields
  localparam int ST_SENT  = 0;
  localparam int ST_COL   = 2;
  localparam int ST_ABORT     = 3;
  localparam int ST_CARRIER   = 4;
  localparam int ST_UNDERRUN  = 5;
  localparam int ST_HEARTBEAT = 6;
  localparam int ST_OWC   = 7;
  // loopback modes
  localparam logic [1:0] LB_NORMAL   = 2'h0;
  localparam logic [1:0] LB_MAC_CORE = 2'h1;
  localparam logic [1:0] LB_ENCDEC   = 2'h2;
  localparam logic [1:0] LB_EXTERNAL = 2'h3;
  // reset values
  localparam logic [7:0] SETUP_RESET  = 8'h00;
  localparam logic [7:0] DATACFG_RST  = 8'h08;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // attempt limit and hash bits
  localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
  localparam logic [5:0] HASH_DISABLE = 6'h3e;
  localparam logic [5:0] HASH_ENABLE  = 6'h3f;
  localparam logic [1:0] OFFSET_COLLS = 2'h3;
  localparam logic [3:0] BACKOFF_CAP  = 4'ha;
  // timing
  localparam int CLK_MHZ       = 20;
  localparam int SLOT_NS       = 51200;
  localparam int HB_WINDOW_NS  = 6400;
  localparam int SLOT_CYC      = SLOT_NS * CLK_MHZ / 1000;
  localparam int HB_CYC        = HB_WINDOW_NS * CLK_MHZ / 1000;
  localparam logic [10:0] SLOT_CYC_W = 11'(SLOT_CYC);
  localparam logic [7:0]  HB_CYC_W   = 8'(HB_CYC);
endpackage

// File: hdl/tx_setup_status.sv
// transmit setup register, transmit outcome status and backoff range
// assumes event inputs are one-cycle pulses synchronous to CLK
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module tx_setup_status
  import txcfg_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // register port
  input  wire logic [3:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  // transmit engine events
  input  wire logic        TX_START,
  input  wire logic        TX_DONE,
  input  wire logic        COLLISION,
  input  wire logic        CARRIER_LOST,
  input  wire logic        FIFO_EMPTY_NO_BUS,
  input  wire logic        HEARTBEAT,
  // receive side special multicast hits
  input  wire logic        MCAST_HIT,
  input  wire logic [5:0]  MCAST_HASH,
  // controls to transmitter and transceiver
  output logic             APPEND_FCS,
  output logic             LOOPBACK_OUTPUT_SIGNAL,
  output logic [1:0]       LOOPBACK_MODE,
  output logic             LOOPBACK_ACTIVE,
  output logic             TX_ENABLE,
  output logic             TX_ABORT,
  output logic             TX_RETRY,
  output logic [3:0]       BACKOFF_EXP
);

  logic [7:0]  setup_q;
  logic [7:0]  datacfg_q;
  logic [7:0]  status_q;
  logic [4:0]  coll_count_q;
  logic        tx_dis_q;
  logic        busy_q;
  logic [10:0] slot_cnt_q;
  logic        hb_wait_q;
  logic [7:0]  hb_cnt_q;
  logic        wr_setup;

  assign wr_setup = WR && (ADDR == ADDR_SETUP);

  // backoff exponent: offset variant or standard truncated exponent
  function automatic logic [3:0] backoff_exp(input logic [4:0] n,
                                             input logic collision_offset_enable);
    logic [4:0] e;
    e = (collision_offset_enable && n <= 5'(OFFSET_COLLS)) ? n + 5'h3 : n;
    if (e > 5'(BACKOFF_CAP))
      e = 5'(BACKOFF_CAP);
    return e[3:0];
  endfunction

  // setup and data configuration registers
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      setup_q   <= SETUP_RESET;
      datacfg_q <= DATACFG_RST;
    end
    else if (WR && ADDR == ADDR_SETUP)
      setup_q   <= {3'h0, WDATA[4:0]};
    else if (WR && ADDR == ADDR_DATACFG)
      datacfg_q <= WDATA;
  end

  // auto transmit disable latch
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      tx_dis_q <= 1'b0;
    else if (wr_setup && !WDATA[SET_AUTO_DIS])
      tx_dis_q <= 1'b0;
    else if (setup_q[SET_AUTO_DIS] && MCAST_HIT
             && MCAST_HASH == HASH_DISABLE)
      tx_dis_q <= 1'b1;
    else if (setup_q[SET_AUTO_DIS] && MCAST_HIT
             && MCAST_HASH == HASH_ENABLE)
      tx_dis_q <= 1'b0;
  end

  // transmission tracking, slot timer and collision count
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      busy_q       <= 1'b0;
      slot_cnt_q   <= 11'h000;
      coll_count_q <= 5'h00;
    end
    else if (TX_START)
    begin
      busy_q       <= 1'b1;
      slot_cnt_q   <= 11'h000;
      coll_count_q <= 5'h00;
    end
    else if (busy_q)
    begin
      if (TX_DONE || TX_ABORT)
        busy_q <= 1'b0;
      if (COLLISION)
      begin
        coll_count_q <= coll_count_q + 5'h01;
        slot_cnt_q   <= 11'h000;
      end
      else if (slot_cnt_q != SLOT_CYC_W)
        slot_cnt_q <= slot_cnt_q + 11'h001;
    end
  end

  // heartbeat window after each transmission that ends with TX_DONE while still busy
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      hb_wait_q <= 1'b0;
      hb_cnt_q  <= 8'h00;
    end
    else if (busy_q && TX_DONE)
    begin
      hb_wait_q <= 1'b1;
      hb_cnt_q  <= 8'h00;
    end
    else if (hb_wait_q)
    begin
      if (HEARTBEAT || TX_START)
        hb_wait_q <= 1'b0;
      else if (hb_cnt_q == HB_CYC_W - 8'h01)
        hb_wait_q <= 1'b0;
      else
        hb_cnt_q <= hb_cnt_q + 8'h01;
    end
  end

  // transmit outcome status; start clears, events only set bits
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      status_q <= STATUS_RESET;
    else if (TX_START)
      status_q <= STATUS_RESET;
    else
    begin
      if (busy_q && COLLISION)
        status_q[ST_COL] <= 1'b1;
      if (busy_q && COLLISION && slot_cnt_q == SLOT_CYC_W)
        status_q[ST_OWC] <= 1'b1;
      if (busy_q && COLLISION && coll_count_q == MAX_ATTEMPTS - 5'h01)
        status_q[ST_ABORT] <= 1'b1;
      if (busy_q && CARRIER_LOST)
        status_q[ST_CARRIER] <= 1'b1;
      if (busy_q && FIFO_EMPTY_NO_BUS)
        status_q[ST_UNDERRUN] <= 1'b1;
      // a final collision in the done cycle still means aborted
      if (busy_q && TX_DONE && !status_q[ST_ABORT]
          && !status_q[ST_UNDERRUN] && !FIFO_EMPTY_NO_BUS
          && !(COLLISION && coll_count_q == MAX_ATTEMPTS - 5'h01))
        status_q[ST_SENT] <= 1'b1;
      if (hb_wait_q && !HEARTBEAT && hb_cnt_q == HB_CYC_W - 8'h01)
        status_q[ST_HEARTBEAT] <= 1'b1;
    end
  end

  // abort, retry and backoff outputs to the transmit engine
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      TX_ABORT    <= 1'b0;
      TX_RETRY    <= 1'b0;
      BACKOFF_EXP <= 4'h0;
    end
    else
    begin
      TX_ABORT <= busy_q && !TX_START && (FIFO_EMPTY_NO_BUS ||
        (COLLISION && coll_count_q == MAX_ATTEMPTS - 5'h01));
      // late collisions retry like ordinary ones
      TX_RETRY <= busy_q && !TX_START && COLLISION && !FIFO_EMPTY_NO_BUS
        && coll_count_q != MAX_ATTEMPTS - 5'h01;
      if (busy_q && !TX_START && COLLISION)
        BACKOFF_EXP <= backoff_exp(coll_count_q + 5'h01,
                                   setup_q[SET_COLL_OFS]);
    end
  end

  // registered controls to transmitter and transceiver
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      APPEND_FCS             <= 1'b1;
      LOOPBACK_OUTPUT_SIGNAL <= 1'b0;
      LOOPBACK_MODE          <= LB_NORMAL;
      LOOPBACK_ACTIVE        <= 1'b0;
      TX_ENABLE              <= 1'b1;
    end
    else
    begin
      // same in loopback and normal modes
      APPEND_FCS <= !setup_q[SET_CRC_INH];
      LOOPBACK_MODE <= setup_q[SET_LB_HIGH:SET_LB_LOW];
      LOOPBACK_OUTPUT_SIGNAL <=
        (setup_q[SET_LB_HIGH:SET_LB_LOW] == LB_ENCDEC);
      LOOPBACK_ACTIVE <= !datacfg_q[DATACFG_LOOP_SEL] &&
        (setup_q[SET_LB_HIGH:SET_LB_LOW] != LB_NORMAL);
      TX_ENABLE <= !tx_dis_q;
    end
  end

  // read data one cycle after the read strobe; setup is write only
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      RDATA <= 8'h00;
    else if (RD && ADDR == ADDR_STATUS)
      RDATA <= status_q;
    else if (RD && ADDR == ADDR_COLLCOUNT)
      RDATA <= {3'h0, coll_count_q};
    else
      RDATA <= 8'h00;
  end

  // loopback and fcs controls follow the setup fields
  AST_LOOPBACK_PIN: assert property (
    @(posedge CLK) disable iff (RESET)
    LOOPBACK_OUTPUT_SIGNAL |-> (LOOPBACK_MODE == LB_ENCDEC))
    else $error("loopback pin high outside encoder loopback");
  AST_LOOPBACK_MODE: assert property (
    @(posedge CLK) disable iff (RESET)
    1'b1 |=> LOOPBACK_MODE == $past(setup_q[SET_LB_HIGH:SET_LB_LOW]))
    else $error("loopback mode does not follow setup field");
  AST_FCS: assert property (
    @(posedge CLK) disable iff (RESET)
    (wr_setup ##1 !wr_setup) |=> APPEND_FCS == !$past(WDATA[SET_CRC_INH], 2))
    else $error("fcs control does not follow crc inhibit");
  AST_FCS_LOOPBACK: assert property (
    @(posedge CLK) disable iff (RESET)
    ($stable(setup_q) && LOOPBACK_MODE != LB_NORMAL)
      |-> APPEND_FCS == !setup_q[SET_CRC_INH])
    else $error("crc inhibit ignored in loopback");
  AST_LOOP_ACTIVE: assert property (
    @(posedge CLK) disable iff (RESET)
    ($stable(setup_q) && $stable(datacfg_q)) |-> LOOPBACK_ACTIVE ==
      (!datacfg_q[DATACFG_LOOP_SEL] && setup_q[2:1] != LB_NORMAL))
    else $error("loopback active does not match select bits");

  // power-up state is normal operation
  AST_RESET_LB: assert property (
    @(posedge CLK)
    $fell(RESET) |-> LOOPBACK_MODE == LB_NORMAL)
    else $error("loopback not normal after reset");
  AST_RESET_PIN: assert property (
    @(posedge CLK)
    $fell(RESET) |-> !LOOPBACK_OUTPUT_SIGNAL && !LOOPBACK_ACTIVE)
    else $error("loopback outputs active after reset");

  // remote transmitter disable by special multicast hits
  AST_AUTODIS_CLEAR: assert property (
    @(posedge CLK) disable iff (RESET)
    (wr_setup && !WDATA[SET_AUTO_DIS]) |=> ##1 TX_ENABLE)
    else $error("clearing auto disable did not enable");
  AST_HASH_DISABLE: assert property (
    @(posedge CLK) disable iff (RESET)
    (setup_q[SET_AUTO_DIS] && MCAST_HIT && MCAST_HASH == HASH_DISABLE
      && !wr_setup) |=> ##1 !TX_ENABLE)
    else $error("disable hash did not stop transmitter");
  AST_HASH_ENABLE: assert property (
    @(posedge CLK) disable iff (RESET)
    (setup_q[SET_AUTO_DIS] && MCAST_HIT && MCAST_HASH == HASH_ENABLE)
      |=> ##1 TX_ENABLE)
    else $error("enable hash did not restart transmitter");
  AST_AUTODIS_OFF: assert property (
    @(posedge CLK) disable iff (RESET)
    !setup_q[SET_AUTO_DIS] |=> !tx_dis_q)
    else $error("transmitter disabled with auto disable off");

  // backoff exponent after each collision
  AST_BACKOFF_OFS: assert property (
    @(posedge CLK) disable iff (RESET)
    (busy_q && !TX_START && COLLISION && setup_q[SET_COLL_OFS]
      && coll_count_q < 5'h03) |=> BACKOFF_EXP == $past(coll_count_q[3:0]) + 4'h4)
    else $error("offset backoff exponent wrong");
  AST_BACKOFF_STD: assert property (
    @(posedge CLK) disable iff (RESET)
    (busy_q && !TX_START && COLLISION && !setup_q[SET_COLL_OFS]
      && coll_count_q < 5'h09) |=> BACKOFF_EXP == $past(coll_count_q[3:0]) + 4'h1)
    else $error("standard backoff exponent wrong");
  AST_BACKOFF_CAP: assert property (
    @(posedge CLK) disable iff (RESET)
    (busy_q && !TX_START && COLLISION && coll_count_q >= 5'h0a)
      |=> BACKOFF_EXP == 4'ha)
    else $error("backoff exponent not capped");

  // status clear at start, quiet between transmissions
  AST_START_CLEARS: assert property (
    @(posedge CLK) disable iff (RESET)
    TX_START |=> status_q == STATUS_RESET)
    else $error("status not cleared at start");
  AST_STATUS_QUIET: assert property (
    @(posedge CLK) disable iff (RESET)
    (!busy_q && !hb_wait_q && !TX_START) |=> $stable(status_q))
    else $error("status changed with no transmission");

  // outcome flags of the current transmission
  AST_SENT_OK: assert property (
    @(posedge CLK) disable iff (RESET)
    $rose(status_q[ST_SENT]) |-> !status_q[ST_ABORT] && !status_q[ST_UNDERRUN])
    else $error("sent ok with abort or underrun");
  AST_SENT_SET: assert property (
    @(posedge CLK) disable iff (RESET)
    (busy_q && !TX_START && TX_DONE && !status_q[ST_ABORT] && !COLLISION
      && !status_q[ST_UNDERRUN] && !FIFO_EMPTY_NO_BUS) |=> status_q[ST_SENT])
    else $error("clean frame not flagged as sent");
  AST_COLL_FLAG: assert property (
    @(posedge CLK) disable iff (RESET)
    (busy_q && !TX_START && COLLISION)
      |=> status_q[ST_COL] && coll_count_q == $past(coll_count_q) + 5'h01)
    else $error("collision not flagged or counted");
  AST_ABORT16: assert property (
    @(posedge CLK) disable iff (RESET)
    (busy_q && !TX_START && COLLISION && coll_count_q == 5'h0f)
      |=> TX_ABORT && status_q[ST_ABORT])
    else $error("no abort on sixteenth attempt");
  AST_ABORT_NO_RETRY: assert property (
    @(posedge CLK) disable iff (RESET)
    TX_ABORT |-> !TX_RETRY)
    else $error("retry requested with abort");

  // carrier loss continues, underrun aborts
  AST_CARRIER_NO_ABORT: assert property (
    @(posedge CLK) disable iff (RESET)
    (busy_q && !TX_START && CARRIER_LOST && !COLLISION && !FIFO_EMPTY_NO_BUS)
      |=> status_q[ST_CARRIER] && !TX_ABORT)
    else $error("carrier loss handled wrongly");
  AST_UNDERRUN: assert property (
    @(posedge CLK) disable iff (RESET)
    (busy_q && !TX_START && FIFO_EMPTY_NO_BUS)
      |=> TX_ABORT && status_q[ST_UNDERRUN])
    else $error("underrun not aborted");

  // heartbeat window and late collisions
  AST_HB_SET: assert property (
    @(posedge CLK) disable iff (RESET)
    (hb_wait_q && !HEARTBEAT && !TX_START && hb_cnt_q == HB_CYC_W - 8'h01)
      |=> status_q[ST_HEARTBEAT])
    else $error("missing heartbeat not flagged");
  AST_HB_SEEN: assert property (
    @(posedge CLK) disable iff (RESET)
    (hb_wait_q && HEARTBEAT && !TX_START) |=> !status_q[ST_HEARTBEAT])
    else $error("heartbeat failure flagged despite heartbeat");
  AST_LATE_RETRY: assert property (
    @(posedge CLK) disable iff (RESET)
    (busy_q && !TX_START && COLLISION && slot_cnt_q == SLOT_CYC_W
      && coll_count_q < 5'h0f && !FIFO_EMPTY_NO_BUS)
      |=> status_q[ST_OWC] && TX_RETRY)
    else $error("late collision not flagged or retried");
endmodule

// File: tb/xcvr_model.sv
// transceiver stand-in: collisions and heartbeat
// assumes coll_req is a one-cycle request from the bench
`timescale 1ns/1ps
module xcvr_model
(
  // clock
  input  wire logic clk,
  // requests from the bench
  input  wire logic coll_req,
  input  wire logic hb_on,
  input  wire logic tx_done,
  // medium events
  output logic      collision,
  output logic      heartbeat
);
  logic [7:0] hb_q = 8'h00;
  // collision a cycle after request
  always_ff @(posedge clk)
    collision <= coll_req;
  // heartbeat ten cycles after frame end, if fitted
  always_ff @(posedge clk)
  begin
    hb_q      <= tx_done ? 8'h0a : hb_q - 8'(hb_q != 8'h00);
    heartbeat <= hb_on && hb_q == 8'h01;
  end
endmodule

// File: tb/testbench.sv
// self-checking bench for transmit setup and outcome status
// assumes the partner model and design sources are compiled first
`timescale 1ns/1ps
module testbench
  import txcfg_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  ev = 4'h0;
  logic        creq = 1'b0;
  logic        hb = 1'b1;
  logic        hit = 1'b0;
  logic [5:0]  hash = 6'h00;
  logic [7:0]  rdata;
  logic        coll, beat, fcs, lbo, lba, txen, txab, rty;
  logic [1:0]  lbm;
  logic [3:0]  bexp;
  logic [31:0] seed = 32'h54a52aac;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          i;
  // system clock
  always #25 clk = ~clk;
  tx_setup_status i_tx_setup_status (.CLK(clk), .RESET(rst),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .TX_START(ev[0]), .TX_DONE(ev[1]), .COLLISION(coll),
    .CARRIER_LOST(ev[2]), .FIFO_EMPTY_NO_BUS(ev[3]), .HEARTBEAT(beat),
    .MCAST_HIT(hit), .MCAST_HASH(hash), .APPEND_FCS(fcs),
    .LOOPBACK_OUTPUT_SIGNAL(lbo), .LOOPBACK_MODE(lbm),
    .LOOPBACK_ACTIVE(lba), .TX_ENABLE(txen), .TX_ABORT(txab),
    .TX_RETRY(rty), .BACKOFF_EXP(bexp));
  xcvr_model i_xcvr_model (.clk(clk), .coll_req(creq), .hb_on(hb),
    .tx_done(ev[1]), .collision(coll), .heartbeat(beat));
  // verdict
  task tally_and_finish;
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // expected backoff exponent
  function automatic logic [3:0] bo(input int n, input logic o);
    int k;
    k = (o && n <= 3) ? n + 3 : n;
    return 4'(k > 10 ? 10 : k);
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // register port cycles
  task wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // one-cycle event: 0 start, 1 done, 2 carrier lost, 3 underrun
  task pls(input int k);
    @(posedge clk);
    ev <= 4'(1 << k);
    @(posedge clk);
    ev <= 4'h0;
  endtask
  task mc(input logic [5:0] h, input logic e);
    @(posedge clk);
    hit  <= 1'b1;
    hash <= h;
    @(posedge clk);
    hit <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(txen, e);
  endtask
  task await_pulse;
    for (int n = 0; n < 8; n++)
    begin
      @(posedge clk);
      #1;
      if ((rty | txab) === 1'b1)
        return;
    end
    chk(8'h01, 8'h00);
    tally_and_finish();
  endtask
  task coll_one(input int n, input logic o, input logic last);
    @(posedge clk);
    creq <= 1'b1;
    @(posedge clk);
    creq <= 1'b0;
    await_pulse();
    chk(txab, last);
    chk(rty, !last);
    if (!last)
      chk(bexp, bo(n, o));
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({fcs, txen, lbo, lbm, lba}, 8'h30);
    wreg(ADDR_DATACFG, 8'h00);
    for (i = 0; i < 8; i++)
    begin
      wreg(ADDR_SETUP, 8'(i));
      chk(fcs, !i[0]);
      chk({lbo, lbm, lba}, {i[2:1] == 2, i[2:1], i[2:1] != 0});
    end
    wreg(ADDR_DATACFG, 8'h08);
    chk(lba, 1'b0);
    rreg(4'h0, 8'h00);
    rreg(ADDR_SETUP, 8'h00);
    wreg(ADDR_SETUP, 8'h08);
    for (i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      mc(seed[5:0] & 6'h3d, 1'b1);
    end
    mc(HASH_DISABLE, 1'b0);
    mc(HASH_ENABLE, 1'b1);
    mc(HASH_DISABLE, 1'b0);
    wreg(ADDR_SETUP, 8'h10);
    chk(txen, 1'b1);
    pls(0);
    for (i = 1; i < 5; i++)
      coll_one(i, 1'b1, 1'b0);
    pls(2);
    pls(1);
    repeat (140) @(posedge clk);
    rreg(ADDR_STATUS, 8'h15);
    rreg(ADDR_COLLCOUNT, 8'h04);
    hb <= 1'b0;
    pls(0);
    pls(1);
    repeat (140) @(posedge clk);
    rreg(ADDR_STATUS, 8'h41);
    hb <= 1'b1;
    pls(0);
    pls(3);
    #1;
    chk(txab, 1'b1);
    rreg(ADDR_STATUS, 8'h20);
    wreg(ADDR_SETUP, 8'h00);
    pls(0);
    for (i = 1; i < 17; i++)
      coll_one(i, 1'b0, i == 16);
    rreg(ADDR_STATUS, 8'h0c);
    rreg(ADDR_COLLCOUNT, 8'h10);
    pls(0);
    repeat (1100) @(posedge clk);
    coll_one(1, 1'b0, 1'b0);
    pls(1);
    repeat (140) @(posedge clk);
    rreg(ADDR_STATUS, 8'h85);
    tally_and_finish();
  end
endmodule
